// file: hdl/fcs_flash_command_sequencer.sv
// Behaviour
// - 16-bit even writes; upper command byte ignored
// - FF enters read array mode
// - 70 makes next read return status
// - 50 clears both error bits
// - 40 then data write starts program
// - Ready flag low during programming
// - Program error flag holds program outcome
// - RAM-exec op start switches to status reads
// - 20 then D0 starts block erase
// - Erase error flag holds erase outcome
// - After RAM-exec erase, status until array/lock read
// - 77 then D0 clears block lock bit
// - 71 then D0 copies lock bit
// - Lock bit 0 protects block
// - Only reset or error-free erase sets lock bit
// - Lock disable ignores lock bits, keeps data
// - Erase with lock disable unlocks block
// - RAM-exec reads status after ops
// - Busy bit low during any operation
// - Status byte: bits 7, 5, 4
// - Errors refuse program, erase, lock program
// - Bad sequence sets both errors
// - No lock error while lock disabled
`timescale 1ns/1ps

module fcs_flash_command_sequencer #(
    parameter int PROG_CYC  = fcs_pkg::PROG_CYCLES,
    parameter int ERASE_CYC = fcs_pkg::ERASE_CYCLES,
    parameter int LOCK_CYC  = fcs_pkg::LOCK_CYCLES
) (
    // Clock and reset
    input  wire logic                          clk,
    input  wire logic                          reset_n,
    input  wire logic                          clk_en,
    // CPU bus into user ROM area
    input  wire fcs_pkg::fcs_bus_s             bus,
    output logic [15:0]                        rdata,
    // Control register bits
    input  wire logic                          ram_exec_rewrite_mode,
    input  wire logic                          rom_exec_rewrite_mode,
    input  wire logic                          lock_disable_bit,
    output logic                               sequencer_ready_flag,
    output logic                               program_error_flag,
    output logic                               erase_error_flag,
    output logic                               lock_status_result,
    output logic [7:0]                         status_byte,
    // Flash array engine
    output fcs_pkg::fcs_array_req_s            array_req,
    input  wire logic                          array_done,
    input  wire logic                          array_fail,
    input  wire logic [15:0]                   array_rdata
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    fcs_pkg::fcs_state_e                 state_q;
    fcs_pkg::fcs_read_mode_e             rmode_q;
    fcs_pkg::fcs_op_e                    op_q;
    logic [fcs_pkg::ADDR_W-1:0]          addr_q;
    logic [fcs_pkg::NUM_BLOCKS-1:0]      lock_q;
    logic                                ready_q;
    logic                                perr_q;
    logic                                eerr_q;
    logic                                lkres_q;
    logic [fcs_pkg::CNT_W-1:0]           cnt_q;
    logic [15:0]                         rdata_q;
    fcs_pkg::fcs_array_req_s             req_q;

    logic                                en_mode;
    logic                                wr_ok;
    logic [7:0]                          cmd;
    logic                                any_err;
    logic [fcs_pkg::BLK_W-1:0]           blk_sel;
    logic [fcs_pkg::BLK_W-1:0]           op_blk;
    logic                                blk_unlocked;
    logic                                op_unlocked;
    logic                                addr_match;
    logic                                op_end;
    logic                                op_fail;
    logic                                bad_seq;
    logic                                start_op;
    fcs_pkg::fcs_op_e                    start_kind;
    logic                                clr_stat;
    logic [fcs_pkg::CNT_W-1:0]           op_cycles;

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    assign en_mode    = ram_exec_rewrite_mode | rom_exec_rewrite_mode;
    assign wr_ok      = clk_en & en_mode & bus.wr & ~bus.addr[0];
    assign cmd        = bus.wdata[7:0];
    assign any_err    = perr_q | eerr_q;
    assign blk_sel    = bus.addr[fcs_pkg::BLK_LSB +: fcs_pkg::BLK_W];
    assign op_blk     = addr_q[fcs_pkg::BLK_LSB +: fcs_pkg::BLK_W];
    assign blk_unlocked = lock_q[blk_sel] | lock_disable_bit;
    assign op_unlocked  = lock_q[op_blk] | lock_disable_bit;
    assign addr_match = (bus.addr == addr_q);
    assign op_end     = (state_q == fcs_pkg::FCS_BUSY) && (cnt_q == '0) && array_done;
    assign op_fail    = array_fail;

    // Second-cycle checks and command start
    always_comb begin
        bad_seq    = 1'b0;
        start_op   = 1'b0;
        start_kind = fcs_pkg::FCS_OP_PROG;
        clr_stat   = 1'b0;
        if (wr_ok) begin
            unique case (state_q)
                fcs_pkg::FCS_WAIT_PROG: begin
                    if (!addr_match) begin
                        bad_seq = 1'b1;
                    end else begin
                        start_op   = 1'b1;
                        start_kind = fcs_pkg::FCS_OP_PROG;
                    end
                end
                fcs_pkg::FCS_WAIT_ERASE: begin
                    if (cmd == fcs_pkg::CMD_CONFIRM) begin
                        start_op   = 1'b1;
                        start_kind = fcs_pkg::FCS_OP_ERASE;
                    end else if (cmd != fcs_pkg::CMD_READ_ARRAY) begin
                        bad_seq = 1'b1;
                    end
                end
                fcs_pkg::FCS_WAIT_LOCK: begin
                    if (cmd == fcs_pkg::CMD_CONFIRM && addr_match) begin
                        start_op   = 1'b1;
                        start_kind = fcs_pkg::FCS_OP_LOCK;
                    end else if (cmd != fcs_pkg::CMD_READ_ARRAY) begin
                        bad_seq = 1'b1;
                    end
                end
                fcs_pkg::FCS_WAIT_RDLOCK: begin
                    if (cmd != fcs_pkg::CMD_CONFIRM && cmd != fcs_pkg::CMD_READ_ARRAY) begin
                        bad_seq = 1'b1;
                    end
                end
                fcs_pkg::FCS_IDLE: begin
                    clr_stat = (cmd == fcs_pkg::CMD_CLEAR_STAT);
                    if (cmd != fcs_pkg::CMD_READ_ARRAY && cmd != fcs_pkg::CMD_READ_STATUS &&
                        cmd != fcs_pkg::CMD_CLEAR_STAT && cmd != fcs_pkg::CMD_PROGRAM &&
                        cmd != fcs_pkg::CMD_ERASE && cmd != fcs_pkg::CMD_LOCK_PROG &&
                        cmd != fcs_pkg::CMD_READ_LOCK) begin
                        bad_seq = 1'b1;
                    end
                end
                default: begin
                    bad_seq = 1'b0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Command state machine
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= fcs_pkg::FCS_IDLE;
            addr_q  <= '0;
            op_q    <= fcs_pkg::FCS_OP_PROG;
        end else if (clk_en) begin
            if (state_q == fcs_pkg::FCS_BUSY) begin
                if (op_end) begin
                    state_q <= fcs_pkg::FCS_IDLE;
                end
            end else if (wr_ok) begin
                if (state_q == fcs_pkg::FCS_IDLE) begin
                    addr_q <= bus.addr;
                    if (!any_err && cmd == fcs_pkg::CMD_PROGRAM) begin
                        state_q <= fcs_pkg::FCS_WAIT_PROG;
                    end else if (!any_err && cmd == fcs_pkg::CMD_ERASE) begin
                        state_q <= fcs_pkg::FCS_WAIT_ERASE;
                    end else if (!any_err && cmd == fcs_pkg::CMD_LOCK_PROG) begin
                        state_q <= fcs_pkg::FCS_WAIT_LOCK;
                    end else if (cmd == fcs_pkg::CMD_READ_LOCK) begin
                        state_q <= fcs_pkg::FCS_WAIT_RDLOCK;
                    end
                end else if (start_op) begin
                    state_q <= fcs_pkg::FCS_BUSY;
                    op_q    <= start_kind;
                    addr_q  <= bus.addr;
                end else begin
                    state_q <= fcs_pkg::FCS_IDLE;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Read mode selection
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rmode_q <= fcs_pkg::FCS_RD_ARRAY;
        end else if (wr_ok) begin
            if (state_q == fcs_pkg::FCS_IDLE && cmd == fcs_pkg::CMD_READ_ARRAY) begin
                rmode_q <= fcs_pkg::FCS_RD_ARRAY;
            end else if (state_q == fcs_pkg::FCS_IDLE && cmd == fcs_pkg::CMD_READ_STATUS) begin
                rmode_q <= fcs_pkg::FCS_RD_STATUS;
            end else if (start_op && ram_exec_rewrite_mode) begin
                // Start wins over FF program data
                rmode_q <= fcs_pkg::FCS_RD_STATUS;
            end else if (state_q == fcs_pkg::FCS_WAIT_RDLOCK ||
                         (state_q != fcs_pkg::FCS_IDLE && state_q != fcs_pkg::FCS_BUSY &&
                          cmd == fcs_pkg::CMD_READ_ARRAY)) begin
                rmode_q <= fcs_pkg::FCS_RD_ARRAY;
            end
        end
    end

    // ------------------------------------------------------------
    // Operation timer and array request
    // ------------------------------------------------------------
    always_comb begin
        unique case (start_kind)
            fcs_pkg::FCS_OP_ERASE: op_cycles = fcs_pkg::CNT_W'(ERASE_CYC);
            fcs_pkg::FCS_OP_LOCK:  op_cycles = fcs_pkg::CNT_W'(LOCK_CYC);
            default:               op_cycles = fcs_pkg::CNT_W'(PROG_CYC);
        endcase
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cnt_q <= '0;
            req_q <= '0;
        end else if (clk_en) begin
            req_q.start <= 1'b0;
            if (start_op) begin
                cnt_q       <= op_cycles - fcs_pkg::CNT_W'(1);
                req_q.start <= (start_kind == fcs_pkg::FCS_OP_LOCK) ? 1'b0 : blk_unlocked;
                req_q.op    <= start_kind;
                req_q.addr  <= bus.addr;
                req_q.data  <= bus.wdata;
            end else if (cnt_q != '0) begin
                cnt_q <= cnt_q - fcs_pkg::CNT_W'(1);
            end
        end
    end

    // ------------------------------------------------------------
    // Ready and error flags
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ready_q <= fcs_pkg::RST_READY;
        end else if (clk_en) begin
            if (start_op) begin
                ready_q <= 1'b0;
            end else if (op_end) begin
                ready_q <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            perr_q <= fcs_pkg::RST_ERR;
            eerr_q <= fcs_pkg::RST_ERR;
        end else if (clk_en) begin
            if (bad_seq) begin
                perr_q <= 1'b1;
                eerr_q <= 1'b1;
            end else if (op_end) begin
                unique case (op_q)
                    fcs_pkg::FCS_OP_PROG:
                        perr_q <= ~op_unlocked | op_fail;
                    fcs_pkg::FCS_OP_ERASE:
                        eerr_q <= ~op_unlocked | op_fail;
                    fcs_pkg::FCS_OP_LOCK:
                        perr_q <= op_fail;
                    default:
                        perr_q <= perr_q;
                endcase
            end else if (clr_stat) begin
                perr_q <= 1'b0;
                eerr_q <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Lock bits and lock status result
    // ------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < fcs_pkg::NUM_BLOCKS; gi++) begin : g_lock
            always_ff @(posedge clk or negedge reset_n) begin
                if (!reset_n) begin
                    lock_q[gi] <= fcs_pkg::RST_LOCK;
                end else if (clk_en && op_end && op_blk == fcs_pkg::BLK_W'(gi)) begin
                    if (op_q == fcs_pkg::FCS_OP_LOCK && !op_fail) begin
                        lock_q[gi] <= 1'b0;
                    end else if (op_q == fcs_pkg::FCS_OP_ERASE && op_unlocked && !op_fail) begin
                        lock_q[gi] <= 1'b1;
                    end
                end
            end
        end
    endgenerate

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            lkres_q <= 1'b0;
        end else if (wr_ok && state_q == fcs_pkg::FCS_WAIT_RDLOCK &&
                     cmd == fcs_pkg::CMD_CONFIRM) begin
            lkres_q <= lock_q[blk_sel];
        end
    end

    // ------------------------------------------------------------
    // Read data path
    // ------------------------------------------------------------
    assign status_byte = {ready_q, 1'b0, eerr_q, perr_q, 4'h0};

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rdata_q <= 16'h0000;
        end else if (clk_en && bus.rd) begin
            if (rmode_q == fcs_pkg::FCS_RD_STATUS) begin
                rdata_q <= {8'h00, status_byte};
            end else begin
                rdata_q <= array_rdata;
            end
        end
    end

    assign rdata                = rdata_q;
    assign sequencer_ready_flag = ready_q;
    assign program_error_flag   = perr_q;
    assign erase_error_flag     = eerr_q;
    assign lock_status_result   = lkres_q;
    assign array_req            = req_q;

endmodule : fcs_flash_command_sequencer

// file: hdl/fcs_pkg.sv
package fcs_pkg;

    // ------------------------------------------------------------
    // Widths and sizes
    // ------------------------------------------------------------
    localparam int ADDR_W      = 17;
    localparam int NUM_BLOCKS  = 8;
    localparam int BLK_W       = 3;
    localparam int BLK_LSB     = 14;

    // ------------------------------------------------------------
    // Command codes (low byte)
    // ------------------------------------------------------------
    localparam logic [7:0] CMD_READ_ARRAY  = 8'hFF;
    localparam logic [7:0] CMD_READ_STATUS = 8'h70;
    localparam logic [7:0] CMD_CLEAR_STAT  = 8'h50;
    localparam logic [7:0] CMD_PROGRAM     = 8'h40;
    localparam logic [7:0] CMD_ERASE       = 8'h20;
    localparam logic [7:0] CMD_LOCK_PROG   = 8'h77;
    localparam logic [7:0] CMD_READ_LOCK   = 8'h71;
    localparam logic [7:0] CMD_CONFIRM     = 8'hD0;

    // ------------------------------------------------------------
    // Status byte layout and reset values
    // ------------------------------------------------------------
    localparam int STAT_READY_POS = 7;
    localparam int STAT_ERASE_POS = 5;
    localparam int STAT_PROG_POS  = 4;
    localparam logic RST_READY    = 1'b1;
    localparam logic RST_ERR      = 1'b0;
    localparam logic RST_LOCK     = 1'b1;

    // ------------------------------------------------------------
    // Operation timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ        = 200;
    localparam int PROG_TIME_US   = 50;
    localparam int ERASE_TIME_US  = 200;
    localparam int LOCK_TIME_US   = 50;
    localparam int PROG_CYCLES    = PROG_TIME_US * CLK_MHZ;
    localparam int ERASE_CYCLES   = ERASE_TIME_US * CLK_MHZ;
    localparam int LOCK_CYCLES    = LOCK_TIME_US * CLK_MHZ;
    localparam int CNT_W          = 24;

    typedef enum logic [1:0] {
        FCS_RD_ARRAY,
        FCS_RD_STATUS
    } fcs_read_mode_e;

    typedef enum logic [2:0] {
        FCS_IDLE,
        FCS_WAIT_PROG,
        FCS_WAIT_ERASE,
        FCS_WAIT_LOCK,
        FCS_WAIT_RDLOCK,
        FCS_BUSY
    } fcs_state_e;

    typedef enum logic [1:0] {
        FCS_OP_PROG,
        FCS_OP_ERASE,
        FCS_OP_LOCK
    } fcs_op_e;

    // CPU-side bus access
    typedef struct packed {
        logic               wr;
        logic               rd;
        logic [ADDR_W-1:0]  addr;
        logic [15:0]        wdata;
    } fcs_bus_s;

    // Array engine request
    typedef struct packed {
        logic               start;
        fcs_op_e            op;
        logic [ADDR_W-1:0]  addr;
        logic [15:0]        data;
    } fcs_array_req_s;

endpackage : fcs_pkg

// file: tb/fcs_array_model.sv
`timescale 1ns/1ps
// --------------------------------------------
// Flash array engine model
// --------------------------------------------
module fcs_array_model (
    // Clock and reset
    input  wire logic                    clk,
    input  wire logic                    reset_n,
    // Request side and test controls
    input  wire fcs_pkg::fcs_array_req_s req,
    input  wire logic [16:0]             rd_addr,
    input  wire logic                    fail_mode,
    input  wire logic                    slow,
    // Engine answers
    output logic                         done,
    output logic                         fail,
    output logic [15:0]                  rdata
);
    logic [4:0] cnt_q;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cnt_q <= 5'h00;
        end else if (req.start) begin
            cnt_q <= slow ? 5'h14 : 5'h02;
        end else if (cnt_q != 5'h00) begin
            cnt_q <= cnt_q - 5'h01;
        end
    end

    assign done  = (cnt_q == 5'h00) && !req.start;
    // Toggles until done
    assign fail  = done ? fail_mode : cnt_q[0];
    assign rdata = {rd_addr[8:1], ~rd_addr[16:9]};
endmodule : fcs_array_model

// file: tb/fcs_flash_command_sequencer_asserts.sv
`timescale 1ns/1ps
// --------------------------------------------
// Port checker
// --------------------------------------------
module fcs_checker #(
    parameter int MIN_CYC = 8
) (
    // Clock and reset
    input wire logic                    clk,
    input wire logic                    reset_n,
    input wire logic                    clk_en,
    // CPU bus and control bits
    input wire fcs_pkg::fcs_bus_s       bus,
    input wire logic [15:0]             rdata,
    input wire logic                    ram_exec_rewrite_mode,
    input wire logic                    rom_exec_rewrite_mode,
    input wire logic                    lock_disable_bit,
    input wire logic                    sequencer_ready_flag,
    input wire logic                    program_error_flag,
    input wire logic                    erase_error_flag,
    input wire logic                    lock_status_result,
    input wire logic [7:0]              status_byte,
    // Array engine
    input wire fcs_pkg::fcs_array_req_s array_req,
    input wire logic                    array_done,
    input wire logic                    array_fail,
    input wire logic [15:0]             array_rdata
);
    logic       acc, err, opc, pend_q, run_q;
    logic [7:0] cmd;
    int         lo_q;

    assign cmd = bus.wdata[7:0];
    assign err = program_error_flag || erase_error_flag;
    assign opc = cmd == fcs_pkg::CMD_PROGRAM || cmd == fcs_pkg::CMD_ERASE
                 || cmd == fcs_pkg::CMD_LOCK_PROG;
    assign acc = clk_en && bus.wr && !bus.addr[0] && sequencer_ready_flag
                 && (ram_exec_rewrite_mode || rom_exec_rewrite_mode);

    // Second cycle pending
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) pend_q <= 1'b0;
        else if (acc) pend_q <= !pend_q && ((opc && !err) || cmd == fcs_pkg::CMD_READ_LOCK);
    end
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) run_q <= 1'b0;
        else if (array_req.start) run_q <= 1'b1;
        else if (sequencer_ready_flag) run_q <= 1'b0;
    end
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) lo_q <= 0;
        else if (clk_en) lo_q <= sequencer_ready_flag ? 0 : lo_q + 1;
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    a_status_layout: assert property (
        status_byte[7] == sequencer_ready_flag && status_byte[5] == erase_error_flag
        && status_byte[4] == program_error_flag) else $error("status bits differ from flags");
    a_reset_idle: assert property (
        $rose(reset_n) |-> sequencer_ready_flag && !err && !array_req.start)
        else $error("not idle after reset");
    a_clear_errors: assert property (
        acc && !pend_q && cmd == fcs_pkg::CMD_CLEAR_STAT |=> !err)
        else $error("clear command left an error flag");
    a_refuse_ops: assert property (
        acc && !pend_q && err && opc |=> (sequencer_ready_flag && !array_req.start)[*2])
        else $error("operation accepted while error flagged");
    a_start_busy: assert property (
        array_req.start |-> !sequencer_ready_flag ##1 !array_req.start)
        else $error("start without busy or longer than one cycle");
    a_busy_min: assert property (
        $rose(sequencer_ready_flag) |-> lo_q >= MIN_CYC - 1)
        else $error("operation ended too early");
    a_busy_ends: assert property (
        $fell(sequencer_ready_flag) |-> ##[1:80] sequencer_ready_flag)
        else $error("operation never ended");
    a_status_read: assert property (
        run_q && !sequencer_ready_flag && ram_exec_rewrite_mode && bus.rd && clk_en
        |=> rdata == {8'h00, $past(status_byte)}) else $error("busy read not status");
endmodule : fcs_checker

bind fcs_flash_command_sequencer fcs_checker #(.MIN_CYC(PROG_CYC)) i_fcs_checker (
    .clk, .reset_n, .clk_en, .bus, .rdata, .ram_exec_rewrite_mode, .rom_exec_rewrite_mode,
    .lock_disable_bit, .sequencer_ready_flag, .program_error_flag, .erase_error_flag,
    .lock_status_result, .status_byte, .array_req, .array_done, .array_fail, .array_rdata);

// file: tb/flash_command_sequencer_bench.sv
`timescale 1ns/1ps
// --------------------------------------------
// Self-checking bench
// --------------------------------------------
module flash_command_sequencer_bench;
    localparam int          N  = 8;
    localparam logic [16:0] B1 = 17'h07FFE;
    localparam logic [16:0] B2 = 17'h0BFFE;
    logic                    clk, reset_n, ram_mode, lock_dis, fail_mode, slow;
    logic                    ready, perr, eerr, lres, done, fail;
    fcs_pkg::fcs_bus_s       bus;
    fcs_pkg::fcs_array_req_s req;
    logic [15:0]             rdata, ardata, d;
    logic [7:0]              stat;
    logic [31:0]             seed, r;
    int                      n_fail, checks;

    fcs_flash_command_sequencer #(.PROG_CYC(N), .ERASE_CYC(N), .LOCK_CYC(N))
    i_fcs_flash_command_sequencer (
        .clk, .reset_n, .clk_en(1'b1), .bus, .rdata,
        .ram_exec_rewrite_mode(ram_mode), .rom_exec_rewrite_mode(1'b0),
        .lock_disable_bit(lock_dis), .sequencer_ready_flag(ready), .program_error_flag(perr),
        .erase_error_flag(eerr), .lock_status_result(lres), .status_byte(stat),
        .array_req(req), .array_done(done), .array_fail(fail), .array_rdata(ardata));
    fcs_array_model i_fcs_array_model (
        .clk, .reset_n, .req, .rd_addr(bus.addr), .fail_mode, .slow, .done, .fail, .rdata(ardata));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    function automatic logic [15:0] word(input logic [16:0] a);
        return {a[8:1], ~a[16:9]};
    endfunction : word
    function automatic logic [15:0] sx(input logic e, input logic p);
        return {8'h00, 1'b1, 1'b0, e, p, 4'h0};
    endfunction : sx
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd

    task automatic final_report();
        $display("checks %0d mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : final_report
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic tick();
        @(posedge clk);
        #1;
    endtask : tick
    task automatic wr(input logic [16:0] a, input logic [15:0] v);
        tick();
        bus.wr = 1'b1;
        bus.addr = a;
        bus.wdata = v;
        tick();
        bus.wr = 1'b0;
        bus.wdata = ~v;
    endtask : wr
    task automatic rd(input logic [16:0] a, output logic [15:0] v);
        tick();
        bus.rd = 1'b1;
        bus.addr = a;
        tick();
        bus.rd = 1'b0;
        v = rdata;
    endtask : rd
    task automatic wait_ready();
        int i;
        for (i = 0; i < 200 && ready !== 1'b1; i++) tick();
        if (i == 200) begin
            n_fail++;
            final_report();
        end
    endtask : wait_ready
    task automatic clr();
        wr(17'h00000, 16'h7750);
        tick();
        chk({perr, eerr}, 16'h0000);
    endtask : clr
    task automatic lockrd(input logic [16:0] a, input logic exp);
        wr(17'h00000, 16'h0071);
        wr(a, 16'h00D0);
        tick();
        chk(lres, exp);
    endtask : lockrd
    // Two-cycle op; go: engine start expected
    task automatic op(input fcs_pkg::fcs_op_e k, input logic [16:0] a, input logic [15:0] v,
                      input logic go);
        logic [7:0] c;
        c = k == fcs_pkg::FCS_OP_PROG ? fcs_pkg::CMD_PROGRAM :
            k == fcs_pkg::FCS_OP_ERASE ? fcs_pkg::CMD_ERASE : fcs_pkg::CMD_LOCK_PROG;
        wr(a, {8'(rnd() >> 24), c});
        wr(a, v);
        chk({req.start, ready}, {go, 1'b0});
        if (go) begin
            chk({req.op, req.addr}, {k, a});
            if (k == fcs_pkg::FCS_OP_PROG) chk(req.data, v);
            rd(a, d);
            chk(d, 16'h0000);
        end
        wait_ready();
    endtask : op

    initial begin
        bus = '0;
        {ram_mode, lock_dis, fail_mode, slow, reset_n} = 5'b10010;
        seed = 32'h0000_0061;
        n_fail = 0;
        checks = 0;
        repeat (8) @(posedge clk);
        #1;
        reset_n = 1'b1;
        chk(stat, sx(1'b0, 1'b0));
        chk({perr, eerr, lres}, 16'h0000);
        wr(17'h00100, 16'hA5FF);
        rd(17'h1FFFE, d);
        chk(d, word(17'h1FFFE));
        wr(17'h00200, 16'h3C70);
        rd(17'h00200, d);
        chk(d, sx(1'b0, 1'b0));
        op(fcs_pkg::FCS_OP_PROG, 17'h00040, 16'hBEEF, 1'b1);
        rd(17'h00040, d);
        chk(d, sx(1'b0, 1'b0));
        fail_mode = 1'b1;
        op(fcs_pkg::FCS_OP_PROG, 17'h00042, 16'h0000, 1'b1);
        chk(stat, sx(1'b0, 1'b1));
        wr(17'h00044, 16'h0040);
        wr(17'h00044, 16'h0070);
        tick();
        chk({req.start, ready, perr, eerr}, 16'h0006);
        clr();
        op(fcs_pkg::FCS_OP_ERASE, B1, 16'h00D0, 1'b1);
        chk({perr, eerr}, 16'h0001);
        clr();
        {fail_mode, slow} = 2'b00;
        op(fcs_pkg::FCS_OP_ERASE, B1, 16'h00D0, 1'b1);
        rd(B1, d);
        chk(d, sx(1'b0, 1'b0));
        lockrd(B1, 1'b1);
        rd(B1, d);
        chk(d, word(B1));
        op(fcs_pkg::FCS_OP_LOCK, B2, 16'h00D0, 1'b0);
        lockrd(B2, 1'b0);
        op(fcs_pkg::FCS_OP_PROG, 17'h08000, 16'h1234, 1'b0);
        chk({perr, eerr}, 16'h0002);
        clr();
        op(fcs_pkg::FCS_OP_ERASE, B2, 16'h00D0, 1'b0);
        chk(eerr, 1'b1);
        clr();
        lock_dis = 1'b1;
        op(fcs_pkg::FCS_OP_PROG, 17'h08000, 16'h1234, 1'b1);
        chk({perr, eerr}, 16'h0000);
        lockrd(B2, 1'b0);
        op(fcs_pkg::FCS_OP_ERASE, B2, 16'h00D0, 1'b1);
        lock_dis = 1'b0;
        lockrd(B2, 1'b1);
        wr(17'h00000, 16'h0020);
        wr(B1, 16'h0055);
        tick();
        chk({perr, eerr}, 16'h0003);
        clr();
        wr(17'h00000, 16'h0020);
        wr(B1, 16'h00FF);
        rd(B1, d);
        chk({perr, eerr, d}, {2'b00, word(B1)});
        for (int i = 0; i < 6; i++) begin
            r = rnd();
            slow = r[0];
            op(fcs_pkg::FCS_OP_PROG, {3'b000, r[13:1], 1'b0}, r[31:16], 1'b1);
            chk(perr, 1'b0);
        end
        final_report();
    end
endmodule : flash_command_sequencer_bench
